// ### rtl/ubm_top.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "ubm_map.svh"
// Functional notes
// RULE1: branch captures destination bits 27..0
// RULE2: valid set on branch, cleared read/enable/reset
// RULE3: reset clears only valid, not address
// RULE4: four-entry queue, shift on each branch
// RULE5: bits 30..28 read zero, write zero
// RULE6: any cycle selection 00 disables channel (code: size field 00 means any size, not off)
// RULE7: software programs cycle select last
// RULE8: match raises break, sets both flags
// RULE9: flags sticky until software writes zero
// RULE10: near-simultaneous breaks give one request
// RULE11: fetch-after bit picks before/after execution
// RULE12: fetch match needs address lsb zero
// RULE13: before-break only for executed fetches
// RULE14: delay slot break waits for acceptor
// RULE15: no such breaks on slot or sleep
// RULE16: after-break fires before next instruction
// RULE17: after-break on delayed branch held off
// RULE18: channel B fetch ignores data compare
// RULE19: local data break only from instructions
// RULE20: address compare width follows access size
// RULE21: channel B needs address and data match
// RULE22: word/byte sizes ignore data bits 31..16
// RULE23: enabled trace records branch destinations
// RULE24: queue advances after target entry read
// RULE25: both channels merge into one request
module ubm_top
   import ubm_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   input wire logic BUS_VALID,
   input wire logic BUS_IS_IBUS,
   input wire logic BUS_IS_FETCH,
   input wire logic BUS_IS_WRITE,
   input wire logic BUS_FROM_INSN,
   input wire logic [1:0] BUS_SIZE,
   input wire logic [31:0] BUS_ADDR,
   input wire logic [31:0] BUS_DATA,
   input wire logic FETCH_FLUSH,
   input wire logic EXEC_VALID,
   input wire logic EXEC_BREAK_OK,
   input wire logic [31:0] EXEC_ADDR,
   input wire logic BRANCH_VALID,
   input wire logic [31:0] BRANCH_DEST,
   output logic TRACE_ADVANCE,
   output logic BREAK_REQ
);
   localparam int NQ = `UBM_TQ_DEPTH;

   ubm_word_t maddr_ff [2];
   ubm_word_t amask_ff [2];
   ubm_csel_t csel_ff [2];
   ubm_word_t mdata_ff;
   ubm_word_t dmask_ff;
   logic [`UBM_CTL_W-1:0] ctl_ff;
   logic [`UBM_CTL_W-1:0] nxt_ctl;
   ubm_word_t rdata_ff;
   logic req_ff;
   logic [1:0] pend_ff;
   logic [1:0] defer_ff;
   ubm_word_t paddr_ff [2];
   logic [1:0] fire;
   logic [1:0] data_hit;
   logic [1:0] fetch_hit;
   logic [NQ-1:0] tv_ff;
   logic [NQ-1:0] nxt_tv;
   ubm_taddr_t ta_ff [NQ];

   wire ctl_wr = REG_WR && (REG_ADDR == `UBM_OFF_CTL);
   wire trace_en = ctl_ff[`UBM_BIT_TE];
   wire trace_rd = REG_RD && (REG_ADDR == `UBM_OFF_BTT);
   wire trace_cap = BRANCH_VALID && trace_en;
   wire trace_start = ctl_wr && REG_WDATA[`UBM_BIT_TE] && !trace_en;
   wire [1:0] fba = {ctl_ff[`UBM_BIT_FBAB], ctl_ff[`UBM_BIT_FBAA]};
   wire exec_ok = EXEC_VALID && EXEC_BREAK_OK;

   // per-channel comparators
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      wire [7:0] oma = (ch == 0) ? `UBM_OFF_MAA : `UBM_OFF_MAB;
      wire [7:0] omk = (ch == 0) ? `UBM_OFF_AMA : `UBM_OFF_AMB;
      wire [7:0] ocs = (ch == 0) ? `UBM_OFF_CSA : `UBM_OFF_CSB;
      wire [1:0] rw = csel_ff[ch][`UBM_CS_RW];
      wire [1:0] fd = csel_ff[ch][`UBM_CS_FD];
      wire [1:0] bs = csel_ff[ch][`UBM_CS_BUS];
      wire [1:0] sz = csel_ff[ch][`UBM_CS_SZ];
      wire en = (rw != 2'h0) && (fd != 2'h0) && (bs != 2'h0); // RULE6
      wire bus_ok = BUS_IS_IBUS ? bs[1] : bs[0];
      wire fd_ok = BUS_IS_FETCH ? fd[0] : fd[1];
      wire rw_ok = BUS_IS_WRITE ? rw[1] : rw[0];
      wire sz_ok = (sz == `UBM_SZ_ANY) || (sz == BUS_SIZE);
      // low address bits drop out with the access size
      wire [31:0] szm = BUS_IS_FETCH ? 32'h0 :
                        (BUS_SIZE == `UBM_SZ_LONG) ? 32'h3 :
                        (BUS_SIZE == `UBM_SZ_WORD) ? 32'h1 : 32'h0; // RULE20
      wire addr_ok = ((BUS_ADDR ^ maddr_ff[ch]) & ~(amask_ff[ch] | szm)) == 32'h0;
      // upper half of data only counts for longword
      wire [31:0] dm = (sz == `UBM_SZ_LONG) ? dmask_ff : (dmask_ff | 32'hffff_0000); // RULE22
      wire dat_ok = (ch == 0) || BUS_IS_FETCH ||
                    (((BUS_DATA ^ mdata_ff) & ~dm) == 32'h0); // RULE18 RULE21
      wire src_ok = BUS_IS_FETCH || BUS_IS_IBUS || BUS_FROM_INSN; // RULE19
      wire hit = BUS_VALID && en && bus_ok && fd_ok && rw_ok && sz_ok && addr_ok;
      wire exec_hit = EXEC_VALID && pend_ff[ch] && (EXEC_ADDR == paddr_ff[ch]);
      wire now = exec_hit && !fba[ch] && EXEC_BREAK_OK; // RULE13
      wire late = defer_ff[ch] && exec_ok; // RULE14 RULE16 RULE17
      assign data_hit[ch] = hit && !BUS_IS_FETCH && dat_ok && src_ok; // RULE21
      assign fetch_hit[ch] = hit && BUS_IS_FETCH && !maddr_ff[ch][0]; // RULE12
      assign fire[ch] = data_hit[ch] || now || late;

      always_ff @(posedge CLK or negedge NRST) begin
         if (!NRST) begin
            maddr_ff[ch] <= `UBM_RST_WORD;
            amask_ff[ch] <= `UBM_RST_WORD;
            csel_ff[ch] <= `UBM_RST_CS;
         end else if (REG_WR) begin
            if (REG_ADDR == oma) maddr_ff[ch] <= REG_WDATA;
            if (REG_ADDR == omk) amask_ff[ch] <= REG_WDATA;
            if (REG_ADDR == ocs) csel_ff[ch] <= REG_WDATA[`UBM_CS_W-1:0];
         end
      end

      // fetched match waits for its own execution; flush drops overrun
      always_ff @(posedge CLK or negedge NRST) begin
         if (!NRST) begin
            pend_ff[ch] <= 1'b0;
            paddr_ff[ch] <= `UBM_RST_WORD;
            defer_ff[ch] <= 1'b0;
         end else begin
            if (fetch_hit[ch]) begin
               pend_ff[ch] <= 1'b1;
               paddr_ff[ch] <= BUS_ADDR;
            end else if (FETCH_FLUSH || exec_hit) begin
               pend_ff[ch] <= 1'b0; // RULE13
            end
            if (exec_hit && (fba[ch] || !EXEC_BREAK_OK)) begin
               defer_ff[ch] <= 1'b1; // RULE11 RULE14 RULE17
            end else if (late) begin
               defer_ff[ch] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         mdata_ff <= `UBM_RST_WORD;
         dmask_ff <= `UBM_RST_WORD;
      end else if (REG_WR) begin
         if (REG_ADDR == `UBM_OFF_MDB) mdata_ff <= REG_WDATA;
         if (REG_ADDR == `UBM_OFF_DMB) dmask_ff <= REG_WDATA;
      end
   end

   // flags: a write of 0 clears, a new match in the same cycle wins
   always_comb begin
      nxt_ctl = ctl_ff;
      if (ctl_wr) begin
         nxt_ctl[`UBM_BIT_FBAA] = REG_WDATA[`UBM_BIT_FBAA];
         nxt_ctl[`UBM_BIT_FBAB] = REG_WDATA[`UBM_BIT_FBAB];
         nxt_ctl[`UBM_BIT_TE] = REG_WDATA[`UBM_BIT_TE];
         nxt_ctl[3:0] = ctl_ff[3:0] & REG_WDATA[3:0]; // RULE9
      end
      if (fire[0]) begin
         nxt_ctl[`UBM_BIT_LMFA] = 1'b1; // RULE8
         nxt_ctl[`UBM_BIT_IMFA] = 1'b1;
      end
      if (fire[1]) begin
         nxt_ctl[`UBM_BIT_LMFB] = 1'b1; // RULE8
         nxt_ctl[`UBM_BIT_IMFB] = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ctl_ff <= `UBM_RST_CTL;
         req_ff <= 1'b0;
      end else begin
         ctl_ff <= nxt_ctl;
         req_ff <= |fire; // RULE10 RULE25
      end
   end

   // trace valid queue, entry 0 is the top
   always_comb begin
      nxt_tv = tv_ff;
      if (trace_start) begin
         nxt_tv = '0; // RULE2
      end else if (trace_cap) begin
         nxt_tv = {tv_ff[NQ-2:0], 1'b1}; // RULE2 RULE4
         if (trace_rd) nxt_tv[1] = 1'b0;
      end else if (trace_rd) begin
         nxt_tv = {1'b0, tv_ff[NQ-1:1]}; // RULE24
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) tv_ff <= '0; // RULE3
      else tv_ff <= nxt_tv;
   end

   // address storage left unreset on purpose
   always_ff @(posedge CLK) begin
      for (int i = 0; i < NQ; i++) begin
         if (trace_cap) begin
            ta_ff[i] <= (i == 0) ? BRANCH_DEST[`UBM_TA_W-1:0] : ta_ff[(i + NQ - 1) % NQ]; // RULE1 RULE23
         end else if (trace_rd && i < NQ - 1) begin
            ta_ff[i] <= ta_ff[i + 1]; // RULE24
         end
      end
   end

   wire [31:0] btt_word = {tv_ff[0], 3'h0, ta_ff[0]}; // RULE5

   wire [31:0] rd_mux =
      (REG_ADDR == `UBM_OFF_MAA) ? maddr_ff[0] :
      (REG_ADDR == `UBM_OFF_AMA) ? amask_ff[0] :
      (REG_ADDR == `UBM_OFF_CSA) ? {24'h0, csel_ff[0]} :
      (REG_ADDR == `UBM_OFF_MAB) ? maddr_ff[1] :
      (REG_ADDR == `UBM_OFF_AMB) ? amask_ff[1] :
      (REG_ADDR == `UBM_OFF_MDB) ? mdata_ff :
      (REG_ADDR == `UBM_OFF_DMB) ? dmask_ff :
      (REG_ADDR == `UBM_OFF_CSB) ? {24'h0, csel_ff[1]} :
      (REG_ADDR == `UBM_OFF_CTL) ? {25'h0, ctl_ff} :
      (REG_ADDR == `UBM_OFF_BTT) ? btt_word : 32'h0;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) rdata_ff <= `UBM_RST_WORD;
      else if (REG_RD) rdata_ff <= rd_mux;
   end

   assign REG_RDATA = rdata_ff;
   assign BREAK_REQ = req_ff;
   assign TRACE_ADVANCE = trace_rd;

   a_req_cause: assert property (@(posedge CLK) disable iff (!NRST)
      BREAK_REQ |-> $past(|fire)) else $error("request without match"); // RULE25
   a_fire_req: assert property (@(posedge CLK) disable iff (!NRST)
      (|fire) |=> BREAK_REQ) else $error("match lost"); // RULE8
   a_flag_set: assert property (@(posedge CLK) disable iff (!NRST)
      fire[1] |=> ctl_ff[`UBM_BIT_LMFB] && ctl_ff[`UBM_BIT_IMFB]) else $error("flag b not set"); // RULE8
   a_flag_sticky: assert property (@(posedge CLK) disable iff (!NRST)
      ctl_ff[`UBM_BIT_LMFA] && !(ctl_wr && !REG_WDATA[`UBM_BIT_LMFA]) |=> ctl_ff[`UBM_BIT_LMFA])
      else $error("flag dropped"); // RULE9
   a_chan_off: assert property (@(posedge CLK) disable iff (!NRST)
      (csel_ff[0][`UBM_CS_RW] == 2'h0) |-> !data_hit[0] && !fetch_hit[0])
      else $error("disabled channel matched"); // RULE6
   a_lsb_block: assert property (@(posedge CLK) disable iff (!NRST)
      maddr_ff[1][0] && BUS_IS_FETCH |-> !fetch_hit[1]) else $error("odd fetch matched"); // RULE12
   a_trace_cap: assert property (@(posedge CLK) disable iff (!NRST)
      trace_cap && !trace_start |=> tv_ff[0] && ta_ff[0] == $past(BRANCH_DEST[27:0]))
      else $error("branch not captured"); // RULE1
   a_trace_clr: assert property (@(posedge CLK) disable iff (!NRST)
      trace_start |=> tv_ff == '0) else $error("valid survived enable"); // RULE2
   a_rsvd_zero: assert property (@(posedge CLK) disable iff (!NRST)
      $past(trace_rd) |-> REG_RDATA[30:28] == 3'h0) else $error("reserved bits set"); // RULE5
   a_after_late: assert property (@(posedge CLK) disable iff (!NRST)
      fba[0] && g_ch[0].exec_hit |-> !fire[0] || data_hit[0] || g_ch[0].late)
      else $error("after-break fired early"); // RULE16

   // the checks below pin down the corner cases the bench reaches only once

   a_flag_set_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE8
      fire[0]
      |=> ctl_ff[`UBM_BIT_LMFA] && ctl_ff[`UBM_BIT_IMFA])
      else $error("flag a not set");

   a_flag_clear: assert property (@(posedge CLK) disable iff (!NRST) // RULE9
      ctl_wr && !REG_WDATA[`UBM_BIT_LMFB] && !fire[1]
      |=> !ctl_ff[`UBM_BIT_LMFB])
      else $error("flag b not cleared");

   a_chan_off_b: assert property (@(posedge CLK) disable iff (!NRST) // RULE6
      (csel_ff[1][`UBM_CS_FD] == 2'h0)
      |-> !data_hit[1] && !fetch_hit[1])
      else $error("channel b matched while off");

   a_bus_off: assert property (@(posedge CLK) disable iff (!NRST) // RULE6
      (csel_ff[0][`UBM_CS_BUS] == 2'h0)
      |-> !data_hit[0] && !fetch_hit[0])
      else $error("channel a matched with no bus");

   a_src_insn: assert property (@(posedge CLK) disable iff (!NRST) // RULE19
      BUS_VALID && !BUS_IS_FETCH && !BUS_IS_IBUS && !BUS_FROM_INSN
      |-> data_hit == 2'b00)
      else $error("local data match not from instruction");

   a_flush_drop: assert property (@(posedge CLK) disable iff (!NRST) // RULE13
      FETCH_FLUSH && !fetch_hit[0]
      |=> !pend_ff[0])
      else $error("overrun fetch kept pending");

   a_before_now: assert property (@(posedge CLK) disable iff (!NRST) // RULE13
      g_ch[0].exec_hit && !fba[0] && EXEC_BREAK_OK
      |=> BREAK_REQ)
      else $error("before-break missed");

   a_slot_hold: assert property (@(posedge CLK) disable iff (!NRST) // RULE14
      g_ch[0].exec_hit && !EXEC_BREAK_OK
      |=> defer_ff[0])
      else $error("slot break not deferred");

   a_after_defer: assert property (@(posedge CLK) disable iff (!NRST) // RULE11 RULE17
      g_ch[1].exec_hit && fba[1]
      |=> defer_ff[1])
      else $error("after-break not deferred");

   a_defer_fire: assert property (@(posedge CLK) disable iff (!NRST) // RULE16
      defer_ff[0] && EXEC_VALID && EXEC_BREAK_OK
      |-> fire[0])
      else $error("deferred break lost");

   a_trace_off: assert property (@(posedge CLK) disable iff (!NRST) // RULE23
      !trace_en && !trace_rd && !trace_start
      |=> tv_ff == $past(tv_ff))
      else $error("queue moved while trace off");

   a_queue_shift: assert property (@(posedge CLK) disable iff (!NRST) // RULE4
      trace_cap && !trace_start && !trace_rd
      |=> tv_ff[NQ-1:1] == $past(tv_ff[NQ-2:0]) && tv_ff[0])
      else $error("queue did not shift");

   a_read_pop: assert property (@(posedge CLK) disable iff (!NRST) // RULE2 RULE24
      trace_rd && !trace_cap && !trace_start
      |=> tv_ff == {1'b0, $past(tv_ff[NQ-1:1])})
      else $error("queue did not pop");

   a_adv_level: assert property (@(posedge CLK) disable iff (!NRST) // RULE24
      TRACE_ADVANCE
      |-> REG_RD)
      else $error("advance without read");

   a_rdata_hold: assert property (@(posedge CLK) disable iff (!NRST)
      !$past(REG_RD)
      |-> $stable(REG_RDATA))
      else $error("read data moved without read");

   a_lsb_block_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE12
      maddr_ff[0][0]
      |-> !fetch_hit[0])
      else $error("odd fetch matched on a");

   a_fetch_nodata: assert property (@(posedge CLK) disable iff (!NRST) // RULE18
      g_ch[1].hit && BUS_IS_FETCH && !maddr_ff[1][0]
      |-> fetch_hit[1])
      else $error("fetch on b blocked by data");

   a_byte_upper: assert property (@(posedge CLK) disable iff (!NRST) // RULE22
      data_hit[1] && (csel_ff[1][`UBM_CS_SZ] != `UBM_SZ_LONG)
      |-> ((BUS_DATA ^ mdata_ff) & ~dmask_ff & 32'h0000_ffff) == 32'h0)
      else $error("low data half mismatched");

   a_long_full: assert property (@(posedge CLK) disable iff (!NRST) // RULE21
      data_hit[1] && (csel_ff[1][`UBM_CS_SZ] == `UBM_SZ_LONG)
      |-> ((BUS_DATA ^ mdata_ff) & ~dmask_ff) == 32'h0)
      else $error("long data mismatched");

   a_long_addr: assert property (@(posedge CLK) disable iff (!NRST) // RULE20
      data_hit[0] && (BUS_SIZE == `UBM_SZ_LONG)
      |-> ((BUS_ADDR ^ maddr_ff[0]) & ~amask_ff[0] & 32'hffff_fffc) == 32'h0)
      else $error("long address mismatched");

   a_byte_addr: assert property (@(posedge CLK) disable iff (!NRST) // RULE20
      data_hit[0] && (BUS_SIZE == `UBM_SZ_BYTE)
      |-> ((BUS_ADDR ^ maddr_ff[0]) & ~amask_ff[0]) == 32'h0)
      else $error("byte address mismatched");

   c_trace_start: cover property (@(posedge CLK) disable iff (!NRST) trace_start);
   c_data_brk: cover property (@(posedge CLK) disable iff (!NRST) data_hit[1]);
   c_both: cover property (@(posedge CLK) disable iff (!NRST) fire[0] && fire[1]);
   c_defer: cover property (@(posedge CLK) disable iff (!NRST) defer_ff[0] ##1 BREAK_REQ);
   c_trace_rd: cover property (@(posedge CLK) disable iff (!NRST) trace_cap ##1 trace_rd);
endmodule : ubm_top

// ### inc/ubm_map.svh
`ifndef UBM_MAP_SVH
`define UBM_MAP_SVH
// register byte offsets
`define UBM_OFF_MAA 8'h00
`define UBM_OFF_AMA 8'h04
`define UBM_OFF_CSA 8'h08
`define UBM_OFF_MAB 8'h0c
`define UBM_OFF_AMB 8'h10
`define UBM_OFF_MDB 8'h14
`define UBM_OFF_DMB 8'h18
`define UBM_OFF_CSB 8'h1c
`define UBM_OFF_CTL 8'h20
`define UBM_OFF_BTT 8'h24
// break_ctrl bit positions
`define UBM_BIT_LMFA 0
`define UBM_BIT_IMFA 1
`define UBM_BIT_LMFB 2
`define UBM_BIT_IMFB 3
`define UBM_BIT_FBAA 4
`define UBM_BIT_FBAB 5
`define UBM_BIT_TE 6
`define UBM_CTL_W 7
// cycle_select field positions
`define UBM_CS_RW 1:0
`define UBM_CS_FD 3:2
`define UBM_CS_BUS 5:4
`define UBM_CS_SZ 7:6
`define UBM_CS_W 8
// operand size codes
`define UBM_SZ_ANY 2'h0
`define UBM_SZ_BYTE 2'h1
`define UBM_SZ_WORD 2'h2
`define UBM_SZ_LONG 2'h3
// trace register layout
`define UBM_TV_BIT 31
`define UBM_TA_W 28
`define UBM_TQ_DEPTH 4
// reset values
`define UBM_RST_WORD 32'h0000_0000
`define UBM_RST_CS 8'h00
`define UBM_RST_CTL 7'h00
`endif

// ### inc/ubm_pkg.sv
`include "ubm_map.svh"
package ubm_pkg;
   typedef logic [31:0] ubm_word_t;
   typedef logic [`UBM_TA_W-1:0] ubm_taddr_t;
   typedef logic [`UBM_CS_W-1:0] ubm_csel_t;
   typedef logic [1:0] ubm_size_t;
endpackage : ubm_pkg

// ### sim/ubm_cpu_model.sv
`timescale 1ns/1ps
module ubm_cpu_model
   import ubm_pkg::*;
(
   input wire logic clk,
   output logic bus_valid,
   output logic bus_is_fetch,
   output logic bus_from_insn,
   output ubm_size_t bus_size,
   output ubm_word_t bus_addr,
   output ubm_word_t bus_data,
   output logic fetch_flush,
   output logic exec_valid,
   output logic exec_break_ok,
   output ubm_word_t exec_addr,
   output logic branch_valid,
   output ubm_word_t branch_dest
);
   initial begin
      {bus_valid, bus_is_fetch, bus_from_insn, fetch_flush, exec_valid, branch_valid} = '0;
      {exec_break_ok, bus_size, bus_addr, bus_data, exec_addr, branch_dest} = '0;
   end
   // idle lines carry inverted junk so a stale value never matches
   task automatic cycle(input logic f, input logic i, input ubm_size_t sz, input ubm_word_t a,
         input ubm_word_t d);
      @(posedge clk);
      {bus_valid, bus_is_fetch, bus_from_insn, bus_size, bus_addr, bus_data} <= {1'b1, f, i, sz, a, d};
      @(posedge clk);
      {bus_valid, bus_addr, bus_data} <= {1'b0, ~a, ~d};
   endtask : cycle
   // fl discards the prefetch, as at a branch overrun
   task automatic step(input logic fl, input logic ok, input ubm_word_t a);
      @(posedge clk);
      {fetch_flush, exec_valid, exec_break_ok, exec_addr} <= {fl, ~fl, ok, a};
      @(posedge clk);
      {fetch_flush, exec_valid, exec_addr} <= {2'b00, ~a};
   endtask : step
   task automatic branch(input ubm_word_t d);
      @(posedge clk);
      {branch_valid, branch_dest} <= {1'b1, d};
      @(posedge clk);
      {branch_valid, branch_dest} <= {1'b0, ~d};
   endtask : branch
endmodule : ubm_cpu_model

// ### sim/user_break_match_and_trace_tb.sv
`timescale 1ns/1ps
`include "ubm_map.svh"
module user_break_match_and_trace_tb
   import ubm_pkg::*;
;
   typedef struct packed {
      logic b;
      ubm_csel_t cs;
      ubm_size_t sz;
      ubm_word_t a;
      ubm_word_t d;
      logic insn;
      logic hit;
   } ubm_row_t;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = '0;
   ubm_word_t reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic bus_is_ibus = 1'b0;
   logic bus_is_write = 1'b0;
   ubm_word_t reg_rdata, bus_addr, bus_data, exec_addr, branch_dest, r;
   logic bus_valid, bus_is_fetch, bus_from_insn, fetch_flush, exec_valid, exec_break_ok;
   logic branch_valid, trace_advance, break_req, adv;
   ubm_size_t bus_size;
   int fail_count = 0;
   int tests_run = 0;
   ubm_row_t rows [11];
   always #20 clk = ~clk;
   ubm_top dut (.CLK(clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .BUS_VALID(bus_valid),
      .BUS_IS_IBUS(bus_is_ibus), .BUS_IS_FETCH(bus_is_fetch), .BUS_IS_WRITE(bus_is_write),
      .BUS_FROM_INSN(bus_from_insn), .BUS_SIZE(bus_size), .BUS_ADDR(bus_addr),
      .BUS_DATA(bus_data), .FETCH_FLUSH(fetch_flush), .EXEC_VALID(exec_valid),
      .EXEC_BREAK_OK(exec_break_ok), .EXEC_ADDR(exec_addr), .BRANCH_VALID(branch_valid),
      .BRANCH_DEST(branch_dest), .TRACE_ADVANCE(trace_advance), .BREAK_REQ(break_req));
   ubm_cpu_model cpu (.clk, .bus_valid, .bus_is_fetch, .bus_from_insn, .bus_size, .bus_addr,
      .bus_data, .fetch_flush, .exec_valid, .exec_break_ok, .exec_addr, .branch_valid,
      .branch_dest);
   task automatic chk(input ubm_word_t got, input ubm_word_t exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input ubm_word_t d);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      #1 adv = trace_advance;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask : rd
   // request must pulse for exactly one cycle
   task automatic brk(input logic e);
      #1 chk(break_req, e);
      @(posedge clk);
      #1 chk(break_req, '0);
   endtask : brk
   task automatic fcase(input logic aft, input logic fl, input logic ok, input ubm_word_t ma,
         input logic e1, input logic e2);
      wr(`UBM_OFF_CSB, '0);
      wr(`UBM_OFF_MAA, ma);
      wr(`UBM_OFF_CTL, {aft, 4'h0});
      wr(`UBM_OFF_CSA, 32'h15);
      cpu.cycle(1'b1, 1'b1, `UBM_SZ_WORD, ma, '0);
      if (fl)
         cpu.step(1'b1, 1'b0, ma);
      cpu.step(1'b0, ok, ma);
      brk(e1);
      cpu.step(1'b0, 1'b1, ma + 32'h2);
      brk(e2);
   endtask : fcase
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial begin
      #400000;
      fail_count++;
      end_sim();
   end
   initial begin
      rows = '{'{0, 8'h19, 3, 32'h1000, 0, 1, 1},
         '{0, 8'h19, 2, 32'h1002, 0, 1, 1},
         '{0, 8'h19, 1, 32'h1003, 0, 1, 1},
         '{0, 8'h19, 1, 32'h1002, 0, 1, 0},
         '{0, 8'h19, 2, 32'h1000, 0, 1, 0},
         '{0, 8'h09, 3, 32'h1000, 0, 1, 0},
         '{0, 8'h11, 3, 32'h1000, 0, 1, 0},
         '{0, 8'h18, 3, 32'h1000, 0, 1, 0},
         '{0, 8'h19, 3, 32'h1000, 0, 0, 0},
         '{1, 8'h99, 2, 32'h1002, 32'h1234, 1, 1},
         '{1, 8'h99, 2, 32'h1002, 32'h1235, 1, 0}};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(`UBM_OFF_CTL);
      chk(r, '0);
      rd(`UBM_OFF_BTT);
      chk(r[31:28], '0);
      rd(8'h30);
      chk(r, '0);
      wr(`UBM_OFF_MAA, 32'h1003);
      wr(`UBM_OFF_MAB, 32'h1003);
      wr(`UBM_OFF_MDB, 32'hffff_1234);
      foreach (rows[i]) begin
         wr(`UBM_OFF_CTL, '0);
         wr(`UBM_OFF_CSA, rows[i].b ? '0 : rows[i].cs);
         wr(`UBM_OFF_CSB, rows[i].b ? rows[i].cs : '0);
         cpu.cycle(1'b0, rows[i].insn, rows[i].sz, rows[i].a, rows[i].d);
         brk(rows[i].hit);
         rd(`UBM_OFF_CTL);
         chk(r[3:0], rows[i].hit ? (rows[i].b ? 4'hc : 4'h3) : 4'h0);
      end
      wr(`UBM_OFF_CTL, '0);
      wr(`UBM_OFF_CSA, 32'h2a);
      {bus_is_ibus, bus_is_write} <= 2'b11;
      cpu.cycle(1'b0, 1'b0, `UBM_SZ_LONG, 32'h1000, '0);
      brk(1'b1);
      rd(`UBM_OFF_CTL);
      chk(r[3:0], 4'h3);
      bus_is_write <= 1'b0;
      cpu.cycle(1'b0, 1'b0, `UBM_SZ_LONG, 32'h1000, '0);
      brk(1'b0);
      bus_is_ibus <= 1'b0;
      wr(`UBM_OFF_DMB, '1);
      wr(`UBM_OFF_CTL, '0);
      wr(`UBM_OFF_CSA, 32'h19);
      wr(`UBM_OFF_CSB, 32'h19);
      cpu.cycle(1'b0, 1'b1, `UBM_SZ_LONG, 32'h1000, '0);
      brk(1'b1);
      rd(`UBM_OFF_CTL);
      chk(r[3:0], 4'hf);
      wr(`UBM_OFF_CTL, 32'h5);
      rd(`UBM_OFF_CTL);
      chk(r[3:0], 4'h5);
      fcase(0, 0, 1, 32'h2000, 1, 0);
      fcase(0, 1, 1, 32'h2000, 0, 0);
      fcase(0, 0, 0, 32'h2000, 0, 1);
      fcase(1, 0, 1, 32'h2000, 0, 1);
      fcase(1, 0, 0, 32'h2000, 0, 1);
      fcase(0, 0, 1, 32'h2001, 0, 0);
      wr(`UBM_OFF_CTL, 32'h40);
      for (int i = 1; i <= 5; i++)
         cpu.branch(32'hf0ab_cde0 + i);
      // only four fit, so the oldest is gone
      for (int i = 5; i >= 2; i--) begin
         rd(`UBM_OFF_BTT);
         chk(r, 32'h80ab_cde0 + i);
         chk(adv, 1'b1);
      end
      rd(`UBM_OFF_BTT);
      chk(r[31], 1'b0);
      cpu.branch(32'hf0ab_cde7);
      wr(`UBM_OFF_CTL, '0);
      wr(`UBM_OFF_CTL, 32'h40);
      rd(`UBM_OFF_BTT);
      chk(r[31], 1'b0);
      cpu.branch(32'hf0ab_cde9);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(`UBM_OFF_BTT);
      chk(r, 32'h00ab_cde9);
      end_sim();
   end
endmodule : user_break_match_and_trace_tb
